// [dv/smris_host.sv]
// Host side model of the shared open-drain reset line.
`default_nettype none
module smris_host (
	input wire logic oe,
	input wire logic hold_low,
	output logic line_n
);
	// The line has a pull-up, so it reads high unless a party pulls it low.
	assign line_n = !(oe || hold_low);
endmodule
`default_nettype wire

// [dv/smris_seq_checker.sv]
// Port-level assertions for the mode, reset and interrupt sequencer.
`default_nettype none
module smris_seq_checker
	import smris_pkg::*;
#(
	parameter logic [1:0] STOP_CODE = MODE_STOP_CODE_DEF,
	parameter int unsigned NREQ_CYC = NREQ_TIMEOUT_CYC
)(
	input wire logic REF_CLK,
	input wire logic RSTN,
	input wire logic MODE_WR,
	input wire logic [1:0] MODE_SELECT_BITS,
	input wire logic SRC_RD,
	input wire logic RST_IN_N,
	input wire logic [WAKE_W-1:0] WAKE_EVT,
	input wire logic RST_OE,
	input wire logic IRQ_N,
	input wire logic [2:0] MODE,
	input wire logic REG_EN
);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RSTN);
	logic [31:0] ncnt;
	////////////////////////////////////////////////////////////////////////
	// Cycles in the request mode; a stuck timer would let this grow.
	always_ff @(posedge REF_CLK) begin
		if (!RSTN || MODE != SMRIS_NREQ)
			ncnt <= 32'h0;
		else
			ncnt <= ncnt + 32'h1;
	end
	////////////////////////////////////////////////////////////////////////
	// Mode transitions and the reset drive.
	property p_oe_mode; RST_OE |-> MODE == SMRIS_RESET; endproperty
	property p_oe_int;
		$rose(MODE == SMRIS_RESET) && RST_IN_N |-> RST_OE;
	endproperty
	property p_boot_hold; $rose(RSTN) |-> RST_OE [*8]; endproperty
	property p_stop_entry;
		$rose(MODE == SMRIS_STOP) |-> $past(MODE_WR) &&
			$past(MODE_SELECT_BITS) == STOP_CODE && $past(MODE) == SMRIS_NORMAL;
	endproperty
	property p_sleep_entry;
		$rose(MODE == SMRIS_SLEEP) |->
			$past(MODE) inside {SMRIS_NORMAL, SMRIS_RESET};
	endproperty
	property p_sleep_reg; (MODE == SMRIS_SLEEP) [*2] |-> !REG_EN; endproperty
	property p_wake_stop;
		MODE == SMRIS_STOP && WAKE_EVT != 4'h0 |-> ##[1:6] MODE == SMRIS_NREQ;
	endproperty
	property p_nreq_bound;
		MODE == SMRIS_NREQ |-> ncnt <= NREQ_CYC + 32'h4;
	endproperty
	a_oe_mode: assert property (p_oe_mode)
		else $error("Reset drive differs from the mode.");
	a_oe_int: assert property (p_oe_int)
		else $error("Internal reset not driven on the pin.");
	a_boot_hold: assert property (p_boot_hold)
		else $error("Reset drive released too early.");
	a_stop_entry: assert property (p_stop_entry)
		else $error("Stop entered without a stop command.");
	a_sleep_entry: assert property (p_sleep_entry)
		else $error("Sleep entered from a wrong mode.");
	a_sleep_reg: assert property (p_sleep_reg)
		else $error("Regulator on in sleep.");
	a_wake_stop: assert property (p_wake_stop)
		else $error("Stop wake did not reach request mode.");
	a_nreq_bound: assert property (p_nreq_bound)
		else $error("Request mode outlived its timeout.");
	////////////////////////////////////////////////////////////////////////
	// Interrupt line.
	property p_irq_mode;
		$fell(IRQ_N) |-> MODE inside {SMRIS_NREQ, SMRIS_NORMAL, SMRIS_STOP};
	endproperty
	property p_irq_hold; !IRQ_N && !SRC_RD |=> !IRQ_N; endproperty
	property p_irq_rel; $rose(IRQ_N) |-> $past(SRC_RD); endproperty
	a_irq_mode: assert property (p_irq_mode)
		else $error("Interrupt raised in a wrong mode.");
	a_irq_hold: assert property (p_irq_hold)
		else $error("Interrupt dropped without a read.");
	a_irq_rel: assert property (p_irq_rel)
		else $error("Interrupt released without a read.");
	c_stop: cover property ($rose(MODE == SMRIS_STOP));
	c_sleep: cover property ($rose(MODE == SMRIS_SLEEP));
	c_irq: cover property ($fell(IRQ_N));
endmodule
`default_nettype wire

// [dv/tb_top.sv]
// Testbench top for the mode, reset and interrupt sequencer.
`default_nettype none
module tb_top
	import smris_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int unsigned RC = 20;
	localparam int unsigned NC = 200;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [5:0] stb = 6'h0;
	logic [1:0] bits = 2'h0;
	logic [7:0] msk = 8'hff;
	logic [7:0] flt = 8'h0;
	logic vdd_low = 1'b0, pwm = 1'b0, cs_n = 1'b1, host_rst = 1'b0;
	logic [3:0] wake = 4'h0;
	wire logic rst_line_n;
	logic rst_oe, irq_n, reg_en, lin_en, bat_fail;
	logic [2:0] mode;
	logic [7:0] src;
	logic [3:0] wsrc;
	int num_errors = 0;
	int comparisons = 0;
	////////////////////////////////////////////////////////////////////////
	// Clock, and a free-running pattern on the modulation pin.
	always #25 clk = ~clk;
	always @(posedge clk) pwm <= ~pwm;
	// Short counts keep the run small; expectations derive from them.
	smris_seq #(.RESET_CYC(RC), .NREQ_CYC(NC), .VLOW_CYC(NC)) smris_seq_i (
		.REF_CLK(clk), .RSTN(rstn), .MODE_WR(stb[0]), .MODE_SELECT_BITS(bits),
		.TIMING_WR(stb[1]), .SRC_RD(stb[2]), .MASK_WR(stb[3]),
		.MASK_DATA(msk), .WD_PERIOD_HALF(stb[5]), .WD_PERIOD_END(stb[4]),
		.WD_STRAP_RES(1'b1), .WD_STRAP_GND(1'b0), .VDD_LOW(vdd_low),
		.SUPPLY_UV(flt[1]), .SUPPLY_OV(flt[2]),
		.REG_OT_WARN(flt[3]), .REG_OT(1'b0), .LIN_FAULT(flt[4]),
		.LIN_TX_RECESSIVE(1'b1), .HS_OT(flt[5]), .LS_OT(flt[6]), .PWM_IN(pwm),
		.CYCLIC_EN(1'b0), .WAKE_EVT(wake), .CS_N(cs_n), .RST_IN_N(rst_line_n),
		.RST_OUT(), .RST_OE(rst_oe), .IRQ_N(irq_n), .MODE(mode),
		.IRQ_SOURCE(src), .WAKE_SOURCE(wsrc), .REG_EN(reg_en),
		.REG_LIMITED(), .SWITCH_EN(), .PWM_GATE(), .WD_ACTIVE(),
		.CYCLIC_PULSE_EN(), .LIN_DRV_EN(lin_en), .REG_OT_FLAG(),
		.BAT_FAIL_SET(bat_fail));
	smris_host smris_host_i (.oe(rst_oe), .hold_low(host_rst),
		.line_n(rst_line_n));
	////////////////////////////////////////////////////////////////////////
	// Shared check, wait and strobe helpers.
	task automatic chk(input string what, input logic [7:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// One-cycle strobe; bit k selects the host access being signalled.
	task automatic strobe(input int k, input logic [1:0] v);
		@(posedge clk);
		bits <= v;
		stb <= 6'h1 << k;
		@(posedge clk);
		stb <= 6'h0;
		#1;
	endtask
	task automatic wait_mode(input logic [2:0] m, input int lim, output int n);
		n = 0;
		while (mode !== m && n < lim) begin
			tick(1);
			n++;
		end
		chk("mode", {5'h0, mode}, {5'h0, m});
	endtask
	task automatic wait_irq(input int lim);
		repeat (lim) if (irq_n === 1'b1) tick(1);
		chk("irq low", {7'h0, irq_n}, 8'h0);
	endtask
	task automatic to_normal();
		int n;
		wait_mode(SMRIS_NREQ, 3 * RC, n);
		strobe(1, 2'h0);
		strobe(0, MODE_NORMAL_CODE);
		wait_mode(SMRIS_NORMAL, 4, n);
	endtask
	task automatic done(input string t);
		$display("test %s done", t);
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	// Watchdog: the tests need well under a tenth of this span.
	initial begin
		#2000000;
		num_errors++;
		give_verdict();
	end
	// Main sequence.
	initial begin
		int n;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		tick(1);
		chk("reset drive", {7'h0, rst_oe}, 8'h1);
		chk("battery fail", {7'h0, bat_fail}, 8'h1);
		wait_mode(SMRIS_NREQ, 3 * RC, n);
		chk("reset span", {7'h0, n >= RC - 2}, 8'h1);
		wait_mode(SMRIS_RESET, NC + 20, n);
		chk("request span", {7'h0, n >= NC - 2}, 8'h1);
		to_normal();
		done("boot");
		for (int i = 1; i < 7; i++) begin
			@(posedge clk) flt <= 8'h1 << i;
			wait_irq(8);
			chk("source", src, 8'h1 << i);
			if (i == IRQ_LIN_FAULT)
				chk("lin driver", {7'h0, lin_en}, 8'h0);
			@(posedge clk) flt <= 8'h0;
			strobe(2, 2'h0);
			tick(1);
			chk("irq release", {7'h0, irq_n}, 8'h1);
		end
		@(posedge clk) msk <= ~(8'h1 << IRQ_SUPPLY_OV);
		strobe(3, 2'h0);
		@(posedge clk) flt <= 8'h4;
		tick(8);
		chk("masked", {7'h0, irq_n}, 8'h1);
		@(posedge clk) flt <= 8'h0;
		msk <= 8'hff;
		strobe(3, 2'h0);
		done("faults");
		strobe(0, MODE_STOP_CODE_DEF);
		wait_mode(SMRIS_STOP, 3, n);
		@(posedge clk) wake <= 4'h1;
		wait_mode(SMRIS_NREQ, 8, n);
		wait_irq(8);
		chk("wake bit", src, 8'h1 << IRQ_WAKE);
		@(posedge clk) wake <= 4'h0;
		strobe(2, 2'h0);
		strobe(0, MODE_STOP_CODE_DEF);
		tick(2);
		chk("stop refused", {5'h0, mode}, {5'h0, SMRIS_NREQ});
		to_normal();
		strobe(0, MODE_STOP_CODE_DEF);
		@(posedge clk) cs_n <= 1'b0;
		@(posedge clk) cs_n <= 1'b1;
		wait_mode(SMRIS_NREQ, 8, n);
		tick(4);
		chk("cs wake irq", {7'h0, irq_n}, 8'h1);
		to_normal();
		done("stop");
		strobe(5, 2'h0);
		strobe(0, MODE_NORMAL_CODE);
		tick(4);
		chk("late clear", {5'h0, mode}, {5'h0, SMRIS_NORMAL});
		strobe(0, MODE_NORMAL_CODE);
		wait_mode(SMRIS_RESET, 8, n);
		to_normal();
		strobe(4, 2'h0);
		wait_mode(SMRIS_RESET, 8, n);
		to_normal();
		done("watchdog");
		@(posedge clk) host_rst <= 1'b1;
		wait_mode(SMRIS_RESET, 8, n);
		tick(3 * RC);
		chk("held", {5'h0, mode}, {5'h0, SMRIS_RESET});
		@(posedge clk) host_rst <= 1'b0;
		wait_mode(SMRIS_NREQ, 6, n);
		to_normal();
		done("reset pin");
		strobe(0, MODE_SLEEP_CODE_DEF);
		wait_mode(SMRIS_SLEEP, 3, n);
		tick(2);
		chk("regulator", {7'h0, reg_en}, 8'h0);
		@(posedge clk) wake <= 4'h2;
		wait_mode(SMRIS_RESET, 8, n);
		chk("wake source", {4'h0, wsrc}, 8'h2);
		chk("battery fail", {7'h0, bat_fail}, 8'h0);
		@(posedge clk) wake <= 4'h0;
		vdd_low <= 1'b1;
		wait_mode(SMRIS_SLEEP, 8, n);
		@(posedge clk) vdd_low <= 1'b0;
		@(posedge clk) wake <= 4'h8;
		wait_mode(SMRIS_RESET, 8, n);
		@(posedge clk) wake <= 4'h0;
		wait_mode(SMRIS_NREQ, 3 * RC, n);
		chk("wake span", {7'h0, n >= RC - 2}, 8'h1);
		done("sleep");
		give_verdict();
	end
endmodule
bind smris_seq smris_seq_checker #(.STOP_CODE(STOP_CODE), .NREQ_CYC(NREQ_CYC))
	smris_seq_checker_i (.REF_CLK(REF_CLK), .RSTN(RSTN), .MODE_WR(MODE_WR),
	.MODE_SELECT_BITS(MODE_SELECT_BITS), .SRC_RD(SRC_RD),
	.RST_IN_N(RST_IN_N), .WAKE_EVT(WAKE_EVT),
	.RST_OE(RST_OE), .IRQ_N(IRQ_N), .MODE(MODE), .REG_EN(REG_EN));
`default_nettype wire

// [rtl/smris_pkg.sv]
// Package with modes, timing counts and interrupt bit positions of the sequencer.
`default_nettype none
package smris_pkg;
	localparam int unsigned CLK_HZ = 20000000;
	localparam int unsigned RESET_LOW_US = 1000;
	localparam int unsigned NREQ_TIMEOUT_MS = 150;
	localparam int unsigned VDD_LOW_SLEEP_MS = 150;
	localparam int unsigned RESET_LOW_CYC = RESET_LOW_US * (CLK_HZ / 1000000);
	localparam int unsigned NREQ_TIMEOUT_CYC = NREQ_TIMEOUT_MS * (CLK_HZ / 1000);
	localparam int unsigned VDD_LOW_SLEEP_CYC =
		VDD_LOW_SLEEP_MS * (CLK_HZ / 1000);
	localparam int unsigned TMR_W = 24;
	localparam logic [1:0] MODE_NORMAL_CODE = 2'h0;
	localparam logic [1:0] MODE_SLEEP_CODE_DEF = 2'h3;
	localparam logic [1:0] MODE_STOP_CODE_DEF = 2'h2;
	localparam int unsigned IRQ_W = 8;
	localparam int unsigned IRQ_WAKE = 0;
	localparam int unsigned IRQ_SUPPLY_UV = 1;
	localparam int unsigned IRQ_SUPPLY_OV = 2;
	localparam int unsigned IRQ_REG_OT_WARN = 3;
	localparam int unsigned IRQ_LIN_FAULT = 4;
	localparam int unsigned IRQ_HS_OT = 5;
	localparam int unsigned IRQ_LS_OT = 6;
	localparam int unsigned IRQ_REG_OT = 7;
	localparam logic [IRQ_W-1:0] MASK_RESET = 8'hff;
	localparam int unsigned WAKE_W = 4;
	typedef enum logic [2:0] {
		SMRIS_RESET = 3'b000,
		SMRIS_NREQ = 3'b001,
		SMRIS_NORMAL = 3'b011,
		SMRIS_STOP = 3'b010,
		SMRIS_SLEEP = 3'b110
	} smris_mode_e;
endpackage
`default_nettype wire

// [rtl/smris_seq.sv]
// Operating mode, reset and interrupt sequencer of the supervisory chip.
`default_nettype none
module smris_seq
	import smris_pkg::*;
#(
	parameter logic [1:0] SLEEP_CODE = MODE_SLEEP_CODE_DEF,
	parameter logic [1:0] STOP_CODE = MODE_STOP_CODE_DEF,
	parameter int unsigned RESET_CYC = RESET_LOW_CYC,
	parameter int unsigned NREQ_CYC = NREQ_TIMEOUT_CYC,
	parameter int unsigned VLOW_CYC = VDD_LOW_SLEEP_CYC
)(
	input wire logic REF_CLK,
	input wire logic RSTN,
	input wire logic MODE_WR,
	input wire logic [1:0] MODE_SELECT_BITS,
	input wire logic TIMING_WR,
	input wire logic SRC_RD,
	input wire logic MASK_WR,
	input wire logic [IRQ_W-1:0] MASK_DATA,
	input wire logic WD_PERIOD_HALF,
	input wire logic WD_PERIOD_END,
	input wire logic WD_STRAP_RES,
	input wire logic WD_STRAP_GND,
	input wire logic VDD_LOW,
	input wire logic SUPPLY_UV,
	input wire logic SUPPLY_OV,
	input wire logic REG_OT_WARN,
	input wire logic REG_OT,
	input wire logic LIN_FAULT,
	input wire logic LIN_TX_RECESSIVE,
	input wire logic HS_OT,
	input wire logic LS_OT,
	input wire logic PWM_IN,
	input wire logic CYCLIC_EN,
	input wire logic [WAKE_W-1:0] WAKE_EVT,
	input wire logic CS_N,
	input wire logic RST_IN_N,
	output logic RST_OUT,
	output logic RST_OE,
	output logic IRQ_N,
	output logic [2:0] MODE,
	output logic [IRQ_W-1:0] IRQ_SOURCE,
	output logic [WAKE_W-1:0] WAKE_SOURCE,
	output logic REG_EN,
	output logic REG_LIMITED,
	output logic SWITCH_EN,
	output logic PWM_GATE,
	output logic WD_ACTIVE,
	output logic CYCLIC_PULSE_EN,
	output logic LIN_DRV_EN,
	output logic REG_OT_FLAG,
	output logic BAT_FAIL_SET
);
	//////////////////////////////////////////////////////////////////////
	// Input synchronisers: status, strap, wake, chip select and reset pins pass two flops before use; host strobes and data are used directly.
	localparam int unsigned NSYNC = 15 + WAKE_W;
	// Chip select and reset pin idle high, so their stages reset high
	// and no false edge follows reset.
	localparam logic [NSYNC-1:0] SYNC_IDLE = NSYNC'(32'h00006000);
	wire logic [NSYNC-1:0] raw_in = {WAKE_EVT, CS_N, RST_IN_N, VDD_LOW,
		SUPPLY_UV, SUPPLY_OV, REG_OT_WARN, REG_OT, LIN_FAULT,
		LIN_TX_RECESSIVE, HS_OT, LS_OT, PWM_IN, WD_STRAP_RES,
		WD_STRAP_GND, CYCLIC_EN};
	logic [NSYNC-1:0] sync1;
	logic [NSYNC-1:0] sync2;

	// The first stage feeds only the second stage.
	always_ff @(posedge REF_CLK) begin
		if (!RSTN) begin
			sync1 <= SYNC_IDLE;
			sync2 <= SYNC_IDLE;
		end else begin
			sync1 <= raw_in;
			sync2 <= sync1;
		end
	end

	wire logic s_cyc_en = sync2[0];
	wire logic s_wd_gnd = sync2[1];
	wire logic s_wd_res = sync2[2];
	wire logic s_pwm = sync2[3];
	wire logic s_ls_ot = sync2[4];
	wire logic s_hs_ot = sync2[5];
	wire logic s_tx_rec = sync2[6];
	wire logic s_lin_flt = sync2[7];
	wire logic s_reg_ot = sync2[8];
	wire logic s_ot_warn = sync2[9];
	wire logic s_sup_ov = sync2[10];
	wire logic s_sup_uv = sync2[11];
	wire logic s_vdd_low = sync2[12];
	wire logic s_rst_n = sync2[13];
	wire logic s_cs_n = sync2[14];
	wire logic [WAKE_W-1:0] s_wake = sync2[NSYNC-1:15];

	//////////////////////////////////////////////////////////////////////
	// Edge history and shared timer.
	logic cs_q;
	logic rst_q;
	logic [IRQ_W-1:0] flt_q;
	smris_mode_e mode;
	smris_mode_e next_mode;
	smris_timer_if tif ();

	smris_timer u_tmr (
		.clk(REF_CLK),
		.rst_n(RSTN),
		.t(tif.tmr)
	);

	wire logic cs_rise = s_cs_n && !cs_q;
	logic oe_q1;
	logic oe_q2;
	logic ext_hold;
	// The pin reads low while we pull it ourselves; our own drive is
	// masked through both sync stages so it is not taken as external.
	wire logic own_drive = RST_OE || oe_q1 || oe_q2;
	wire logic ext_rst = !s_rst_n && !own_drive;
	// An external reset is not driven back, so its release stays visible.
	wire logic next_ext_hold = (next_mode == SMRIS_RESET) &&
		((mode == SMRIS_RESET) ? ext_hold && !s_vdd_low && !s_reg_ot :
		ext_rst);
	wire logic ext_rel = s_rst_n && !rst_q;
	wire logic dev_wake = |s_wake;
	wire logic [TMR_W-1:0] tcount = tif.count;

	// In Reset mode, reset conditions hold the reset pin low while present; VDD low without undervoltage goes to Sleep instead.
	wire logic rst_cond = s_vdd_low || s_reg_ot;
	wire logic mode_cmd = MODE_WR && (mode == SMRIS_NORMAL);
	wire logic cmd_sleep = mode_cmd && MODE_SELECT_BITS == SLEEP_CODE;
	wire logic cmd_stop = mode_cmd && MODE_SELECT_BITS == STOP_CODE;
	wire logic cmd_normal = MODE_WR && MODE_SELECT_BITS == MODE_NORMAL_CODE;

	// Windowed watchdog, active in Normal only with a resistor strap.
	logic wd_half;
	wire logic wd_on = (mode == SMRIS_NORMAL) && s_wd_res;
	wire logic wd_clear = wd_on && cmd_normal;
	wire logic wd_fail = wd_on && ((wd_clear && !wd_half) ||
		(WD_PERIOD_END && !wd_clear));

	// Normal Request needs the timing write before the normal command.
	logic tim_done;
	wire logic nreq_ok = (mode == SMRIS_NREQ) && cmd_normal && tim_done;
	wire logic nreq_to = (mode == SMRIS_NREQ) && tcount >= TMR_W'(NREQ_CYC);
	wire logic rst_done = tcount >= TMR_W'(RESET_CYC);
	wire logic vlow_to = s_vdd_low && tcount >= TMR_W'(VLOW_CYC);
	wire logic after_rst = s_wd_gnd ? 1'b1 : 1'b0;

	//////////////////////////////////////////////////////////////////////
	// Mode transitions.
	always_comb begin
		next_mode = mode;
		case (mode)
			SMRIS_RESET: begin
				if (s_vdd_low && !s_sup_uv && !ext_rst) begin
					next_mode = SMRIS_SLEEP;
				end else if (ext_rst || rst_cond) begin
					next_mode = SMRIS_RESET;
				end else if (ext_rel || rst_done) begin
					// External release skips the extended low time.
					next_mode = after_rst ? SMRIS_NORMAL : SMRIS_NREQ;
				end
			end
			SMRIS_NREQ: begin
				if (ext_rst || s_reg_ot || nreq_to) begin
					next_mode = SMRIS_RESET;
				end else if (nreq_ok) begin
					next_mode = SMRIS_NORMAL;
				end
			end
			SMRIS_NORMAL: begin
				if (cmd_sleep || (vlow_to && !s_sup_uv)) begin
					next_mode = SMRIS_SLEEP;
				end else if (ext_rst || wd_fail || s_reg_ot) begin
					next_mode = SMRIS_RESET;
				end else if (cmd_stop) begin
					next_mode = SMRIS_STOP;
				end
			end
			SMRIS_STOP: begin
				if (ext_rst) begin
					next_mode = SMRIS_RESET;
				end else if (dev_wake || cs_rise) begin
					next_mode = after_rst ? SMRIS_NORMAL : SMRIS_NREQ;
				end
			end
			SMRIS_SLEEP: begin
				if (dev_wake) begin
					next_mode = SMRIS_RESET;
				end
			end
			default: next_mode = SMRIS_RESET;
		endcase
	end

	// Timer restarts on every mode change, while reset sources persist in Reset, and in Normal while VDD is not low.
	assign tif.clear = (next_mode != mode) ||
		(mode == SMRIS_RESET && rst_cond) ||
		(mode == SMRIS_NORMAL && !s_vdd_low);

	//////////////////////////////////////////////////////////////////////
	// Interrupt sources and the active-low interrupt pin.
	logic [IRQ_W-1:0] src_reg;
	logic [IRQ_W-1:0] mask_reg;
	wire logic [IRQ_W-1:0] flt_now;
	wire logic [IRQ_W-1:0] flt_evt;
	wire logic normal_like = (mode == SMRIS_NORMAL) || (mode == SMRIS_NREQ);
	wire logic stop_wake = (mode == SMRIS_STOP) && dev_wake && !ext_rst;
	wire logic irq_ok = !ext_rst && (normal_like || mode == SMRIS_STOP);
	wire logic wake_pending = src_reg[IRQ_WAKE];

	assign flt_now[IRQ_WAKE] = 1'b0;
	assign flt_now[IRQ_SUPPLY_UV] = s_sup_uv;
	assign flt_now[IRQ_SUPPLY_OV] = s_sup_ov;
	assign flt_now[IRQ_REG_OT_WARN] = s_ot_warn;
	assign flt_now[IRQ_LIN_FAULT] = s_lin_flt;
	assign flt_now[IRQ_HS_OT] = s_hs_ot;
	assign flt_now[IRQ_LS_OT] = s_ls_ot;
	assign flt_now[IRQ_REG_OT] = s_reg_ot;

	// Rising fault edges only, masked and gated by mode.
	genvar gi;
	generate
		for (gi = 0; gi < IRQ_W; gi++) begin : g_evt
			assign flt_evt[gi] = flt_now[gi] && !flt_q[gi] && mask_reg[gi] &&
				normal_like && irq_ok;
		end
	endgenerate

	// Wake from Stop flags the source unless chip select or reset woke it.
	wire logic [IRQ_W-1:0] set_vec = flt_evt |
		(IRQ_W'(stop_wake) << IRQ_WAKE);
	// Set wins over the read-clear so a coincident event is not lost.
	wire logic [IRQ_W-1:0] next_isr = (SRC_RD ? '0 : src_reg) | set_vec;
	// New interrupts wait until pending wake sources have been read.
	wire logic irq_fire = irq_ok && (|set_vec) &&
		(!wake_pending || SRC_RD || set_vec[IRQ_WAKE]);
	wire logic next_irq_n = SRC_RD ? !irq_fire :
		(irq_fire ? 1'b0 : (irq_ok ? IRQ_N : 1'b1));

	// Wake source latched on Stop or Sleep wake for SPI report.
	wire logic sleep_wake = (mode == SMRIS_SLEEP) && dev_wake;
	wire logic [WAKE_W-1:0] next_wake_src =
		(stop_wake || sleep_wake) ? s_wake :
		(SRC_RD ? '0 : WAKE_SOURCE);

	// LIN driver latches off on a fault and recovers once recessive.
	logic lin_off;
	wire logic next_lin_off = s_lin_flt ? 1'b1 :
		((lin_off && s_tx_rec) ? 1'b0 : lin_off);

	//////////////////////////////////////////////////////////////////////
	// State and status registers.
	always_ff @(posedge REF_CLK) begin
		if (!RSTN) begin
			mode <= SMRIS_RESET;
			cs_q <= 1'b1;
			rst_q <= 1'b1;
			flt_q <= '0;
			src_reg <= '0;
			mask_reg <= MASK_RESET;
			IRQ_N <= 1'b1;
			WAKE_SOURCE <= '0;
			lin_off <= 1'b0;
			wd_half <= 1'b0;
			tim_done <= 1'b0;
			oe_q1 <= 1'b1;
			oe_q2 <= 1'b1;
			ext_hold <= 1'b0;
		end else begin
			mode <= next_mode;
			cs_q <= s_cs_n;
			rst_q <= s_rst_n;
			flt_q <= flt_now;
			src_reg <= next_isr;
			mask_reg <= MASK_WR ? MASK_DATA : mask_reg;
			IRQ_N <= next_irq_n;
			WAKE_SOURCE <= next_wake_src;
			lin_off <= next_lin_off;
			wd_half <= (!wd_on || wd_clear || WD_PERIOD_END) ? 1'b0 :
				(WD_PERIOD_HALF ? 1'b1 : wd_half);
			tim_done <= (mode != SMRIS_NREQ) ? 1'b0 : (tim_done || TIMING_WR);
			oe_q1 <= RST_OE;
			oe_q2 <= oe_q1;
			ext_hold <= next_ext_hold;
		end
	end

	// Registered mode-dependent outputs.
	always_ff @(posedge REF_CLK) begin
		if (!RSTN) begin
			RST_OUT <= 1'b0;
			RST_OE <= 1'b1;
			MODE <= 3'h0;
			IRQ_SOURCE <= '0;
			REG_EN <= 1'b1;
			REG_LIMITED <= 1'b0;
			SWITCH_EN <= 1'b0;
			PWM_GATE <= 1'b0;
			WD_ACTIVE <= 1'b0;
			CYCLIC_PULSE_EN <= 1'b0;
			LIN_DRV_EN <= 1'b0;
			REG_OT_FLAG <= 1'b0;
			BAT_FAIL_SET <= 1'b1;
		end else begin
			// Reset pin is pulled low in Reset mode unless the host holds it.
			RST_OUT <= 1'b0;
			RST_OE <= (next_mode == SMRIS_RESET) && !next_ext_hold;
			MODE <= next_mode;
			IRQ_SOURCE <= next_isr;
			REG_EN <= (next_mode != SMRIS_SLEEP) && !s_reg_ot;
			REG_LIMITED <= (next_mode == SMRIS_STOP);
			SWITCH_EN <= (next_mode == SMRIS_NORMAL) ||
				(next_mode == SMRIS_NREQ);
			PWM_GATE <= s_pwm && (next_mode == SMRIS_NORMAL);
			WD_ACTIVE <= (next_mode == SMRIS_NORMAL) && s_wd_res;
			CYCLIC_PULSE_EN <= s_cyc_en && ((next_mode == SMRIS_STOP) ||
				(next_mode == SMRIS_SLEEP));
			LIN_DRV_EN <= (next_mode == SMRIS_NORMAL) && !next_lin_off;
			REG_OT_FLAG <= REG_OT_FLAG || s_reg_ot;
			// Battery fail only marks the first power-up, never a sleep wake.
			BAT_FAIL_SET <= BAT_FAIL_SET && !sleep_wake;
		end
	end
endmodule
`default_nettype wire

// [rtl/smris_timer.sv]
// Saturating mode timer shared by reset, request and sleep-entry timeouts.
`default_nettype none
module smris_timer
	import smris_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	smris_timer_if.tmr t
);
	logic [TMR_W-1:0] cnt;
	wire logic at_max = &cnt;
	wire logic [TMR_W-1:0] next_cnt = t.clear ? '0 :
		(at_max ? cnt : cnt + 24'h000001);

	// Counts up from each clear and saturates, so no timeout can wrap.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt <= '0;
		end else begin
			cnt <= next_cnt;
		end
	end
	assign t.count = cnt;
endmodule
`default_nettype wire

// [rtl/smris_timer_if.sv]
// Interface carrying mode timer control between the sequencer and its timer.
`default_nettype none
interface smris_timer_if;
	import smris_pkg::*;
	logic clear;
	logic [TMR_W-1:0] count;
	modport ctrl (output clear, input count);
	modport tmr (input clear, output count);
endinterface
`default_nettype wire
